// ===== rtl/asu_pkg.sv
/*
   shared constants of the async serial unit: register map, field positions,
   reset values, frame timing and state types.
   assumes: imported by every module of the unit.
*/
`default_nettype none
package asu_pkg;
   localparam int BUS_W = 32;
   localparam int DIV_W = 13;
   // byte offsets of the word registers
   localparam logic [7:0] ADDR_BAUD = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0c;
   localparam logic [7:0] ADDR_BOTH = 8'h10;
   // control field positions
   localparam int CB_LOOP = 14;
   localparam int CB_OD   = 13;
   localparam int CB_IDT  = 12;
   localparam int CB_ODD  = 11;
   localparam int CB_PE   = 10;
   localparam int CB_WAKE = 8;
   localparam int CB_TE   = 3;
   localparam int CB_RE   = 2;
   localparam int CB_RWK  = 1;
   localparam int CB_BRK  = 0;
   // status field positions
   localparam int FB_TXE  = 8;
   localparam int FB_TXC  = 7;
   localparam int FB_RXF  = 6;
   localparam int FB_OVR  = 3;
   // reset values and masks
   localparam logic [DIV_W-1:0] BAUD_RST = 13'h0000;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] CTRL_MASK = 16'h7fff;
   localparam logic [8:0]  FLAG_RST  = 9'h180;
   localparam logic [8:0]  RX_MASK   = 9'h05f;
   localparam logic [8:0]  TX_MASK   = 9'h180;
   localparam logic [8:0]  HOLD_MASK = 9'h1df;
   // sixteen ticks per bit, three samples around mid bit
   localparam logic [3:0]  PH_LAST   = 4'hf;
   localparam logic [3:0]  SMP_FIRST = 4'h7;
   localparam logic [3:0]  SMP_LAST  = 4'h9;
   localparam logic [3:0]  BIT_STOP  = 4'h9;
   localparam logic [7:0]  IDLE_TICKS     = 8'ha0;
   localparam logic [7:0]  IDLE_TICKS_PAR = 8'hb0;
   localparam logic [10:0] BREAK_FRAME = 11'h000;
   localparam logic [10:0] MARK_FRAME  = 11'h7ff;
   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} asu_tx_t;
   typedef enum logic {RX_IDLE = 1'b0, RX_FRAME = 1'b1} asu_rx_t;
endpackage
`default_nettype wire

// ===== rtl/asu_link_if.sv
/*
   signals between the unit's top, its rate generator and its receiver.
   assumes: instantiated once inside the top module.
*/
`default_nettype none
interface asu_link_if;
   logic [12:0] div;
   logic        tick;
   logic        line;
   logic        idle_type;
   logic        pe;
   logic        odd;
   logic        re;
   logic [7:0]  data;
   logic        load;
   logic        nerr;
   logic        ferr;
   logic        perr;
   logic        active;
   logic        idle_det;
   modport gen (input div, output tick);
   modport rxs (input tick, line, idle_type, pe, odd, re,
                output data, load, nerr, ferr, perr, active, idle_det);
   modport top (output div, line, idle_type, pe, odd, re,
                input tick, data, load, nerr, ferr, perr, active, idle_det);
endinterface
`default_nettype wire

// ===== rtl/asu_baud.sv
/*
   rate generator: one tick every two divisor clocks, sixteen ticks a bit.
   assumes: divisor held in a register of the top.
*/
`default_nettype none
module asu_baud (
   input wire logic ref_clk,
   input wire logic arst_n,
   asu_link_if.gen  lk
);
   import asu_pkg::*;
   logic [13:0] cnt_reg;
   logic        tick_reg;
   // tick period is twice the divisor
   wire logic [13:0] period_w = {lk.div, 1'b0};
   wire logic        hit_w    = cnt_reg >= period_w - 14'h0001;
   // counter stops outright on a zero divisor
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg  <= 14'h0000;
         tick_reg <= 1'b0;
      end
      else if (lk.div == BAUD_RST)
      begin
         cnt_reg  <= 14'h0000;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= hit_w ? 14'h0000 : cnt_reg + 14'h0001;
         tick_reg <= hit_w;
      end
   end
   assign lk.tick = tick_reg;
   a_baud_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (lk.div == BAUD_RST) [*2] |-> !lk.tick)
      else $error("tick while divisor zero");
   a_baud_rate: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (lk.tick && lk.div == 13'h0001 && $past(lk.div) == 13'h0001) |=> !lk.tick ##1 lk.tick)
      else $error("fastest rate not two clocks a tick");
endmodule
`default_nettype wire

// ===== rtl/asu_top.sv
/*
   async serial unit: AHB-Lite register slave, transmitter, flag logic and pins;
   instantiates the rate generator and the receiver.
   assumes: one clock, inputs synchronous, a single AHB-Lite master.
*/
// Behaviour
// - zero divisor stops the rate generator
// - divisor one fastest, rate inverse to divisor
// - control resets zero, writable any time
// - loopback feeds receiver, output pin idles high
// - open drain drives low only, else push-pull
// - idle type picks when idle counting starts
// - odd select chooses parity both directions
// - break sends zero frames after current frame
// - short break gives at most one frame
// - status read then data access clears flags
// - combined word read clears receive flags only
// - flag set after status read survives
// - status word read arms all flags, combined word read arms transmit flags only
// - empty flag resets one, sets on load
// - holding data sent only after clear sequence
// - complete flag resets one, sets when drained
// - full flag and errors set together
// - active flag set on start, cleared idle
// - hardware may clear only the wakeup bit
`default_nettype none
module asu_top (
   input  wire logic                      ref_clk,
   input  wire logic                      arst_n,
   input  wire logic                      hsel,
   input  wire logic [asu_pkg::BUS_W-1:0] haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [asu_pkg::BUS_W-1:0] hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [asu_pkg::BUS_W-1:0]      hrdata,
   input  wire logic                      rxd_in,
   output logic                           txd_out,
   output logic                           txd_oe
);
   import asu_pkg::*;

   asu_link_if lk ();

   logic              pend_reg;
   logic              wr_reg;
   logic [7:0]        adr_reg;
   logic [31:0]       hrdata_reg;
   logic [DIV_W-1:0]  baud_reg;
   logic [15:0]       ctrl_reg;
   logic [8:0]        flag_reg;
   logic [8:0]        arm_reg;
   logic [7:0]        txh_reg;
   logic [7:0]        rxh_reg;
   asu_tx_t           tx_state_reg;
   logic [3:0]        tx_ph_reg;
   logic [3:0]        tx_bit_reg;
   logic [10:0]       tx_sh_reg;
   logic              pre_reg;
   logic              te_d_reg;
   logic              pin_out_reg;
   logic              pin_oe_reg;

   // address phase accepted; one wait state follows every transfer
   wire logic acc_w = hsel && htrans[1] && hready;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pend_reg <= 1'b0;
         wr_reg   <= 1'b0;
         adr_reg  <= 8'h00;
      end
      else
      begin
         pend_reg <= acc_w;
         if (acc_w)
         begin
            wr_reg  <= hwrite;
            adr_reg <= haddr[7:0];
         end
      end
   end

   // word decode; a byte of the status word selects the whole word
   wire logic sel_baud_w = pend_reg && adr_reg[7:2] == ADDR_BAUD[7:2];
   wire logic sel_ctrl_w = pend_reg && adr_reg[7:2] == ADDR_CTRL[7:2];
   wire logic sel_stat_w = pend_reg && adr_reg[7:2] == ADDR_STAT[7:2];
   wire logic sel_data_w = pend_reg && adr_reg[7:2] == ADDR_DATA[7:2];
   wire logic sel_both_w = pend_reg && adr_reg[7:2] == ADDR_BOTH[7:2];
   wire logic wr_baud_w  = sel_baud_w && wr_reg;
   wire logic wr_ctrl_w  = sel_ctrl_w && wr_reg;
   wire logic rd_stat_w  = sel_stat_w && !wr_reg;
   wire logic rd_data_w  = sel_data_w && !wr_reg;
   wire logic wr_data_w  = sel_data_w && wr_reg;
   wire logic rd_both_w  = sel_both_w && !wr_reg;

   // status word as software sees it
   wire logic [15:0] stat_w = {7'h00, flag_reg};

   // read selection; unmapped words read zero
   wire logic [31:0] rd_mux_w =
      sel_baud_w ? {19'h00000, baud_reg} :
      sel_ctrl_w ? {16'h0000, ctrl_reg} :
      sel_stat_w ? {16'h0000, stat_w} :
      sel_data_w ? {24'h000000, rxh_reg} :
      sel_both_w ? {stat_w, 8'h00, rxh_reg} : 32'h00000000;

   // read data registered at the end of the wait state
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         hrdata_reg <= 32'h00000000;
      else if (pend_reg && !wr_reg)
         hrdata_reg <= rd_mux_w;
   end

   assign hreadyout = ~pend_reg;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // divisor register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         baud_reg <= BAUD_RST;
      else if (wr_baud_w)
         baud_reg <= hwdata[DIV_W-1:0];
   end

   // hardware touches only the wakeup bit, on idle line wakeup
   wire logic rwu_clr_w = lk.idle_det && !ctrl_reg[CB_WAKE];

   // control register, writable at any moment
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_reg <= CTRL_RST;
      else if (wr_ctrl_w)
         ctrl_reg <= hwdata[15:0] & CTRL_MASK;
      else if (rwu_clr_w)
         ctrl_reg[CB_RWK] <= 1'b0;
   end

   // clear sequence: data access clears only what the status read saw
   wire logic [8:0] clr_w =
      rd_data_w ? (arm_reg & RX_MASK) :
      wr_data_w ? (arm_reg & TX_MASK) :
      rd_both_w ? (flag_reg & RX_MASK) : 9'h000;
   wire logic full_busy_w = flag_reg[FB_RXF] && !clr_w[FB_RXF];
   wire logic rx_take_w   = lk.load && !ctrl_reg[CB_RWK];
   wire logic load_ok_w   = rx_take_w && !full_busy_w;

   // transmitter decisions; break first, then preamble, then data
   wire logic        te_w        = ctrl_reg[CB_TE];
   wire logic [3:0]  tx_last_w   = BIT_STOP + {3'h0, ctrl_reg[CB_PE]};
   wire logic        par_bit_w   = (^txh_reg) ^ ctrl_reg[CB_ODD];
   wire logic [10:0] data_frame_w = {1'b1, ctrl_reg[CB_PE] ? par_bit_w : 1'b1, txh_reg, 1'b0};
   wire logic        tx_free_w   = tx_state_reg == TX_IDLE && te_w;
   wire logic        brk_go_w    = tx_free_w && ctrl_reg[CB_BRK];
   wire logic        pre_go_w    = tx_free_w && !ctrl_reg[CB_BRK] && pre_reg;
   wire logic        tx_load_w   = tx_free_w && !ctrl_reg[CB_BRK] && !pre_reg && !flag_reg[FB_TXE];
   wire logic        tx_step_w   = tx_state_reg == TX_SHIFT && lk.tick && tx_ph_reg == PH_LAST;
   wire logic        tx_done_w   = tx_step_w && tx_bit_reg == tx_last_w;
   wire logic        txc_set_w   = tx_done_w && !ctrl_reg[CB_BRK] && !pre_reg
                                   && flag_reg[FB_TXE] && !clr_w[FB_TXE];
   // between back-to-back breaks the shifter still holds a zero, so the line never blips high
   wire logic        tx_line_w   = (tx_state_reg == TX_SHIFT || brk_go_w) ? tx_sh_reg[0] : 1'b1;

   // flag sets; a set wins over a clear in the same cycle
   wire logic [8:0] set_w = {tx_load_w, txc_set_w, load_ok_w, lk.active, lk.idle_det,
                             rx_take_w && full_busy_w, load_ok_w && lk.nerr,
                             load_ok_w && lk.ferr, load_ok_w && lk.perr};
   wire logic [8:0] flag_next = (flag_reg & ~clr_w & HOLD_MASK) | set_w;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_reg <= FLAG_RST;
      else
         flag_reg <= flag_next;
   end

   // arming snapshot; flags set later are not in it
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         arm_reg <= 9'h000;
      else if (rd_stat_w)
         arm_reg <= flag_reg;
      else if (rd_both_w)
         arm_reg <= flag_reg & ~RX_MASK;
      else if (rd_data_w)
         arm_reg <= arm_reg & ~RX_MASK;
      else if (wr_data_w)
         arm_reg <= arm_reg & ~TX_MASK;
   end

   // holding registers; a write while not empty overwrites
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         txh_reg <= 8'h00;
         rxh_reg <= 8'h00;
      end
      else
      begin
         if (wr_data_w)
            txh_reg <= hwdata[7:0];
         if (load_ok_w)
            rxh_reg <= lk.data;
      end
   end

   // preamble queued when the transmitter is enabled
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         te_d_reg <= 1'b0;
         pre_reg  <= 1'b0;
      end
      else
      begin
         te_d_reg <= te_w;
         if (te_w && !te_d_reg)
            pre_reg <= 1'b1;
         else if (pre_go_w)
            pre_reg <= 1'b0;
      end
   end

   // transmit shifter; a running frame always completes
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_state_reg <= TX_IDLE;
         tx_ph_reg    <= 4'h0;
         tx_bit_reg   <= 4'h0;
         tx_sh_reg    <= MARK_FRAME;
      end
      else if (brk_go_w || pre_go_w || tx_load_w)
      begin
         tx_state_reg <= TX_SHIFT;
         tx_ph_reg    <= 4'h0;
         tx_bit_reg   <= 4'h0;
         tx_sh_reg    <= brk_go_w ? BREAK_FRAME : (pre_go_w ? MARK_FRAME : data_frame_w);
      end
      else if (tx_state_reg == TX_SHIFT && lk.tick)
      begin
         tx_ph_reg <= tx_ph_reg + 4'h1;
         if (tx_done_w)
            tx_state_reg <= TX_IDLE;
         else if (tx_step_w)
         begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
         end
      end
   end

   // pin: loopback holds it idle, open drain only pulls low
   wire logic pin_line_w = ctrl_reg[CB_LOOP] ? 1'b1 : tx_line_w;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_out_reg <= 1'b1;
         pin_oe_reg  <= 1'b0;
      end
      else
      begin
         pin_out_reg <= ctrl_reg[CB_OD] ? 1'b0 : pin_line_w;
         pin_oe_reg  <= te_w && (!ctrl_reg[CB_OD] || !pin_line_w);
      end
   end

   assign txd_out = pin_out_reg;
   assign txd_oe  = pin_oe_reg;

   // link to the rate generator and receiver
   assign lk.div       = baud_reg;
   assign lk.line      = ctrl_reg[CB_LOOP] ? tx_line_w : rxd_in;
   assign lk.idle_type = ctrl_reg[CB_IDT];
   assign lk.pe        = ctrl_reg[CB_PE];
   assign lk.odd       = ctrl_reg[CB_ODD];
   assign lk.re        = ctrl_reg[CB_RE];

   asu_baud u_baud (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .lk      (lk)
   );

   asu_rx u_rx (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .lk      (lk)
   );

   a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_ctrl_w |=> ctrl_reg == ($past(hwdata[15:0]) & CTRL_MASK))
      else $error("control write not stored");
   a_loop_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $past(ctrl_reg[CB_LOOP]) |-> (txd_out || !txd_oe))
      else $error("pin not idle in loopback");
   a_open_drain: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $past(ctrl_reg[CB_OD]) |-> !txd_out && (txd_oe == $past(te_w && !pin_line_w)))
      else $error("open drain pin drove high");
   a_break_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      brk_go_w |=> (!tx_line_w) [*8])
      else $error("break frame not low");
   a_clear_rx: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rd_data_w && arm_reg[FB_RXF] && !lk.load) |=> !flag_reg[FB_RXF])
      else $error("armed full flag not cleared");
   a_both_keep: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rd_both_w && flag_reg[FB_TXE] && flag_reg[FB_TXC]) |=> flag_reg[FB_TXE] && flag_reg[FB_TXC])
      else $error("combined read cleared transmit flags");
   a_late_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rd_data_w && !arm_reg[FB_RXF] && flag_reg[FB_RXF]) |=> flag_reg[FB_RXF])
      else $error("unarmed flag cleared");
   a_empty_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
      tx_load_w |=> flag_reg[FB_TXE] && tx_state_reg == TX_SHIFT && tx_sh_reg[8:1] == $past(txh_reg))
      else $error("empty flag not set on load");
   a_hold_unarmed: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (tx_free_w && flag_reg[FB_TXE] && !ctrl_reg[CB_BRK] && !pre_reg) |=> tx_state_reg == TX_IDLE)
      else $error("sent data without clear sequence");
   a_done_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
      txc_set_w |=> flag_reg[FB_TXC] && tx_state_reg == TX_IDLE)
      else $error("complete flag not set when drained");
   a_rx_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (load_ok_w && lk.ferr) |=> flag_reg[FB_RXF] && flag_reg[1] && rxh_reg == $past(lk.data))
      else $error("full and error flags not together");
endmodule
`default_nettype wire

// ===== rtl/asu_rx.sv
/*
   receiver: start detect, majority sampling, parity check, idle detect.
   assumes: ticks at sixteen per bit, line synchronous to the clock.
*/
`default_nettype none
module asu_rx (
   input wire logic ref_clk,
   input wire logic arst_n,
   asu_link_if.rxs  lk
);
   import asu_pkg::*;
   asu_rx_t    state_reg;
   logic [3:0] ph_reg;
   logic [3:0] bit_reg;
   logic [1:0] smp_reg;
   logic [7:0] sh_reg;
   logic [7:0] data_reg;
   logic [7:0] idle_reg;
   logic       par_reg;
   logic       noise_reg;
   logic       load_reg;
   logic       nerr_reg;
   logic       ferr_reg;
   logic       perr_reg;
   logic       act_reg;
   logic       idet_reg;
   // majority vote and sample timing
   wire logic maj_w   = (smp_reg[1] & smp_reg[0]) | (smp_reg[1] & lk.line) | (smp_reg[0] & lk.line);
   wire logic noisy_w = ~(smp_reg[1] & smp_reg[0] & lk.line) & (smp_reg[1] | smp_reg[0] | lk.line);
   wire logic mid_w   = lk.tick && state_reg == RX_FRAME && ph_reg == SMP_LAST;
   wire logic [3:0] stop_w = BIT_STOP + {3'h0, lk.pe};
   wire logic is_stop_w = mid_w && bit_reg == stop_w;
   wire logic is_par_w  = mid_w && lk.pe && bit_reg == BIT_STOP;
   wire logic false_w   = mid_w && bit_reg == 4'h0 && maj_w;
   wire logic start_w   = lk.re && lk.tick && state_reg == RX_IDLE && !lk.line;
   // idle counting: short type counts from any one, long only after stop
   wire logic [7:0] lim_w = lk.pe ? IDLE_TICKS_PAR : IDLE_TICKS;
   wire logic cnt_en_w    = lk.tick && lk.line && (!lk.idle_type || state_reg == RX_IDLE);
   wire logic idle_hit_w  = cnt_en_w && idle_reg == lim_w - 8'h01 && act_reg;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         idle_reg <= 8'h00;
      else if ((lk.tick && !lk.line) || (lk.idle_type && state_reg == RX_FRAME))
         idle_reg <= 8'h00;
      else if (cnt_en_w && idle_reg != lim_w)
         idle_reg <= idle_reg + 8'h01;
   end
   // frame sequencer
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= RX_IDLE;
         ph_reg    <= 4'h0;
         bit_reg   <= 4'h0;
         smp_reg   <= 2'h0;
         sh_reg    <= 8'h00;
         par_reg   <= 1'b0;
         noise_reg <= 1'b0;
      end
      else if (!lk.re)
         state_reg <= RX_IDLE;
      else if (start_w)
      begin
         state_reg <= RX_FRAME;
         ph_reg    <= 4'h0;
         bit_reg   <= 4'h0;
         par_reg   <= 1'b0;
         noise_reg <= 1'b0;
      end
      else if (lk.tick && state_reg == RX_FRAME)
      begin
         ph_reg <= ph_reg + 4'h1;
         if (ph_reg == SMP_FIRST || ph_reg == SMP_FIRST + 4'h1)
            smp_reg <= {smp_reg[0], lk.line};
         if (mid_w)
         begin
            noise_reg <= noise_reg | noisy_w;
            if (bit_reg != 4'h0 && !is_stop_w)
            begin
               par_reg <= par_reg ^ maj_w;
               if (!is_par_w)
                  sh_reg <= {maj_w, sh_reg[7:1]};
            end
         end
         if (false_w || is_stop_w)
            state_reg <= RX_IDLE;
         if (ph_reg == PH_LAST)
            bit_reg <= bit_reg + 4'h1;
      end
   end
   // word and its error bits leave together
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         load_reg <= 1'b0;
         data_reg <= 8'h00;
         nerr_reg <= 1'b0;
         ferr_reg <= 1'b0;
         perr_reg <= 1'b0;
         act_reg  <= 1'b0;
         idet_reg <= 1'b0;
      end
      else
      begin
         load_reg <= is_stop_w;
         idet_reg <= idle_hit_w;
         act_reg  <= start_w | (act_reg & ~idle_hit_w);
         if (is_stop_w)
         begin
            data_reg <= sh_reg;
            nerr_reg <= noise_reg | noisy_w;
            ferr_reg <= !maj_w;
            perr_reg <= lk.pe && (par_reg != lk.odd);
         end
      end
   end
   assign lk.data     = data_reg;
   assign lk.load     = load_reg;
   assign lk.nerr     = nerr_reg;
   assign lk.ferr     = ferr_reg;
   assign lk.perr     = perr_reg;
   assign lk.active   = act_reg;
   assign lk.idle_det = idet_reg;
   a_raf_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (start_w |=> lk.active) and (lk.idle_det |-> !lk.active))
      else $error("active flag wrong at start or idle");
endmodule
`default_nettype wire

// ===== test/asu_peer.sv
/*
   far serial peer: sends one 8N1 frame on rxd when go rises.
   assumes: bit_clks set before go, line idles high.
*/
`default_nettype none
module asu_peer (
   input  wire logic       ref_clk,
   input  wire logic       go,
   input  wire logic [7:0] data,
   input  wire logic [15:0] bit_clks,
   output logic            rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] frm;
   // start, data lsb first, stop
   initial
   begin
      rxd = 1'b1;
      forever
      begin
         @(posedge go);
         frm = {1'b1, data, 1'b0};
         for (int i = 0; i < 10; i++)
         begin
            @(posedge ref_clk);
            rxd <= frm[i];
            repeat (bit_clks - 1) @(posedge ref_clk);
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/asu_top_tb.sv
/*
   bench of the async serial unit: AHB-Lite reads and writes, tx on the wire, rx from the peer.
   assumes: one wait state per transfer, divisor 1 gives 32 clocks a bit.
*/
`default_nettype none
module asu_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import asu_pkg::*;
   logic ref_clk, arst_n, hwrite, go, txd_out, txd_oe, hreadyout, hresp, rxd;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0] pdat;
   int error_cnt, total_checks, low_base;
   int low_cnt = 0;
   wire line = txd_oe ? txd_out : 1'b1; // pulled high when not driven
   asu_top u_asu_top (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rxd_in(rxd), .txd_out(txd_out), .txd_oe(txd_oe));
   asu_peer u_asu_peer (.ref_clk(ref_clk), .go(go), .data(pdat), .bit_clks(16'h0020), .rxd(rxd));
   // clock and low-time counter on the wire
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (line === 1'b0) low_cnt++;
   // one single transfer: address phase, then data phase; hready sampled at rising edges
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #3000000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      arst_n = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; go = 1'b0; pdat = 8'h3c;
      error_cnt = 0; total_checks = 0; low_base = 0;
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      ahb(0, ADDR_CTRL, 0); chk(rd, 32'h0);
      ahb(1, ADDR_CTRL, 32'h1234); ahb(0, ADDR_CTRL, 0); chk(rd, 32'h1234);
      ahb(1, ADDR_CTRL, 32'h000c);
      ahb(1, ADDR_DATA, 32'h11); // no status read yet, so nothing is armed
      ahb(0, ADDR_STAT, 0); chk(rd, 32'h180);
      repeat (700) @(posedge ref_clk); chk(low_cnt, 0);
      ahb(1, ADDR_BAUD, 32'h1);
      repeat (700) @(posedge ref_clk); chk(low_cnt, 0);
      ahb(0, ADDR_STAT, 0); ahb(1, ADDR_DATA, 32'ha5);
      repeat (700) @(posedge ref_clk); chk(low_cnt, 160);
      ahb(0, ADDR_STAT, 0); chk(rd, 32'h180);
      go <= 1'b1;
      repeat (400) @(posedge ref_clk);
      ahb(0, ADDR_STAT, 0); chk(rd & 32'h1c7, 32'h1c0);
      ahb(0, ADDR_DATA, 0); chk(rd, 32'h3c);
      ahb(0, ADDR_STAT, 0); chk(rd & 32'h040, 32'h0);
      low_base = low_cnt;
      ahb(1, ADDR_CTRL, 32'h400c);
      ahb(0, ADDR_STAT, 0); ahb(1, ADDR_DATA, 32'h5a);
      repeat (700) @(posedge ref_clk); chk(low_cnt - low_base, 0);
      ahb(0, ADDR_STAT, 0); chk(rd & 32'h047, 32'h040);
      ahb(0, ADDR_BOTH, 0); chk(rd & 32'h01c700ff, 32'h01c0005a);
      ahb(0, ADDR_STAT, 0); chk(rd & 32'h1c0, 32'h180);
      ahb(0, ADDR_DATA, 0); chk(rd, 32'h5a);
      ahb(1, ADDR_CTRL, 32'h2c0c); ahb(0, ADDR_STAT, 0); ahb(1, ADDR_DATA, 32'h5b);
      repeat (700) @(posedge ref_clk); chk(low_cnt - low_base, 160);
      chk(txd_oe, 0);
      low_base = low_cnt;
      ahb(1, ADDR_CTRL, 32'h000d); repeat (100) @(posedge ref_clk); chk(line, 0);
      ahb(1, ADDR_CTRL, 32'h000c); repeat (700) @(posedge ref_clk); chk(low_cnt - low_base, 320);
      summarize();
   end
endmodule
`default_nettype wire
